//--- hdl/rtc_i2c_host.sv
// two-wire bus master that reads and writes the rtc register and user spaces
// Function
// [RULE_01] bytes go most significant bit first
// [RULE_02] data changes only while clock low
// [RULE_03] device leaves data released after power-up
// [RULE_04] device ignores everything before a start
// [RULE_05] stop returns device to standby
// [RULE_06] transmitter releases, receiver acks ninth clock
// [RULE_07] device acks word address and written data
// [RULE_08] master acks each read byte wanting more
// [RULE_09] device ids 1101111 and 1010111 are matched
// [RULE_10] address lsb one reads, zero writes
// [RULE_11] word address pointer starts at zero
// [RULE_12] random read reuses same slave id
// [RULE_13] write is start, id, word, data, stop
// [RULE_14] random read uses repeated start, id read
// [RULE_15] reads continue while master acks, stop ends
// [RULE_16] register pointer wraps after 2fh to zero
// [RULE_17] user memory is 128 bytes, own id
// [RULE_18] turnover temperature at 2ch is read only
// [RULE_19] turnover code: 0.5 degree steps, sign bit four
// [RULE_20] hot curvature at 2dh is magnitude times 2048
// [RULE_21] hot curvature is read only
// [RULE_22] master starts every transfer and drives clock
// [RULE_23] unmatched id gets no ack
// [RULE_24] both lines pass synchronisers and edge detection; the host synchronises and filters levels only, with no edge detection
`include "rtc_host_regs.svh"
module rtc_i2c_host
  import rtc_host_pkg::*;
#(
  parameter int QUARTER = `QUARTER_CYC  // sys cycles per quarter serial period
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // software register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [31:0] reg_rdata,
  // serial clock pin
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  // serial data pin
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);

  // software-visible state
  logic        read_r;          // transfer is a read
  logic        user_r;          // user memory space selected
  logic        cur_r;           // current-address read, no word byte
  logic [7:0]  word_r;          // word address to send
  logic [7:0]  wdata_r;         // data byte to write
  logic [7:0]  rdata_r;         // last byte read
  logic [7:0]  count_r;         // bytes still to read
  logic        busy_r;          // transfer running
  logic        done_r;          // transfer finished (sticky)
  logic        nack_r;          // device refused a byte (sticky)
  logic [15:0] div_r;           // quarter period in sys cycles
  // engine state
  host_state_t state_r;         // bit-level state
  host_phase_t phase_r;         // byte-level phase
  logic [15:0] tick_r;          // quarter-period counter
  logic [1:0]  qtr_r;           // quarter index within a bit
  logic [2:0]  bit_r;           // bit index within a byte
  logic [7:0]  shift_r;         // byte being shifted
  logic        scl_low_r;       // we pull the clock low
  logic        sda_low_r;       // we pull data low
  logic [2:0]  scl_sync_r;      // clock-pin synchroniser
  logic [2:0]  sda_sync_r;      // data-pin synchroniser
  logic        scl_s_r;         // filtered clock level
  logic        sda_s_r;         // filtered data level
  logic        go;              // start pulse from software
  logic        step;            // end of a quarter period

  // open-drain pins only ever drive low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = scl_low_r;                                             // [RULE_22]
  assign sda_oe  = sda_low_r;

  assign go   = reg_wr && (reg_addr == `HOST_CTRL_OFS) && reg_wdata[`CTRL_GO_BIT] && !busy_r;
  assign step = (tick_r == 16'h0000);

  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      scl_s_r    <= 1'b1;
      sda_s_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};                            // [RULE_24]
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
      if (scl_sync_r[1] == scl_sync_r[2]) begin
        scl_s_r <= scl_sync_r[2];
      end
      if (sda_sync_r[1] == sda_sync_r[2]) begin
        sda_s_r <= sda_sync_r[2];
      end
    end
  end

  // software configuration writes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      read_r  <= 1'b0;
      user_r  <= 1'b0;
      cur_r   <= 1'b0;
      word_r  <= 8'h00;
      wdata_r <= 8'h00;
      div_r   <= 16'(QUARTER);
    end else if (reg_wr) begin
      unique case (reg_addr)
        `HOST_CTRL_OFS: begin
          if (!busy_r) begin
            read_r <= reg_wdata[`CTRL_READ_BIT];
            user_r <= reg_wdata[`CTRL_SPACE_BIT];
            cur_r  <= reg_wdata[`CTRL_CUR_BIT];
          end
        end
        `HOST_ADDR_OFS:  word_r  <= reg_wdata[7:0];
        `HOST_WDATA_OFS: wdata_r <= reg_wdata[7:0];
        `HOST_DIV_OFS:   div_r   <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `HOST_CTRL_OFS:   reg_rdata <= {28'h0, cur_r, user_r, read_r, 1'b0};
        `HOST_ADDR_OFS:   reg_rdata <= {24'h0, word_r};
        `HOST_WDATA_OFS:  reg_rdata <= {24'h0, wdata_r};
        `HOST_RDATA_OFS:  reg_rdata <= {24'h0, rdata_r};
        `HOST_STATUS_OFS: reg_rdata <= {29'h0, nack_r, done_r, busy_r};
        `HOST_COUNT_OFS:  reg_rdata <= {24'h0, count_r};
        `HOST_DIV_OFS:    reg_rdata <= {16'h0, div_r};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // quarter-period timebase, held while the device stretches the clock
  always_ff @(posedge sys_clk) begin
    if (!reset_n || state_r == st_idle) begin
      tick_r <= 16'h0000;
    end else if (!scl_low_r && !scl_s_r) begin
      tick_r <= tick_r;
    end else if (step) begin
      tick_r <= div_r - 16'h0001;
    end else begin
      tick_r <= tick_r - 16'h0001;
    end
  end

  // byte sequencer and bit engine
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r   <= st_idle;
      phase_r   <= ph_slave_w;
      qtr_r     <= 2'h0;
      bit_r     <= 3'h7;
      shift_r   <= 8'h00;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;                                                  // [RULE_03]
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      nack_r    <= 1'b0;
      rdata_r   <= 8'h00;
      count_r   <= 8'h00;
    end else begin
      // sticky flags cleared by writing ones; new events win
      if (reg_wr && reg_addr == `HOST_STATUS_OFS) begin
        if (reg_wdata[`STAT_DONE_BIT]) done_r <= 1'b0;
        if (reg_wdata[`STAT_NACK_BIT]) nack_r <= 1'b0;
      end
      if (reg_wr && reg_addr == `HOST_COUNT_OFS && !busy_r) begin
        count_r <= reg_wdata[7:0];
      end
      unique case (state_r)
        st_idle: begin
          if (go) begin
            busy_r  <= 1'b1;
            qtr_r   <= 2'h0;
            state_r <= st_start;
            // current read goes straight to the read id
            phase_r <= (reg_wdata[`CTRL_READ_BIT] && reg_wdata[`CTRL_CUR_BIT]) ? ph_slave_r
                                                                              : ph_slave_w;
          end
        end
        st_start: if (step) begin
          // data falls while clock high, then clock falls
          qtr_r <= qtr_r + 2'h1;
          if (qtr_r == 2'h0) begin scl_low_r <= 1'b0; end
          if (qtr_r == 2'h1) begin sda_low_r <= 1'b1; end                 // [RULE_04]
          if (qtr_r == 2'h2) begin scl_low_r <= 1'b1; end
          if (qtr_r == 2'h3) begin
            bit_r   <= 3'h7;
            state_r <= st_send;
            // id byte: seven-bit identifier then direction
            unique case (phase_r)
              ph_slave_w: shift_r <= {user_r ? `DEV_ID_USER : `DEV_ID_REGS, 1'b0}; // [RULE_09] [RULE_10]
              ph_slave_r: shift_r <= {user_r ? `DEV_ID_USER : `DEV_ID_REGS, 1'b1}; // [RULE_12] [RULE_14]
              default:    shift_r <= 8'h00;
            endcase
          end
        end
        st_send: if (step) begin
          qtr_r <= qtr_r + 2'h1;
          // data set while clock low, clock pulses after
          if (qtr_r == 2'h0) begin sda_low_r <= !shift_r[7]; end          // [RULE_01] [RULE_02]
          if (qtr_r == 2'h1) begin scl_low_r <= 1'b0; end
          if (qtr_r == 2'h3) begin
            scl_low_r <= 1'b1;
            shift_r   <= {shift_r[6:0], 1'b0};
            bit_r     <= bit_r - 3'h1;
            if (bit_r == 3'h0) begin state_r <= st_sack; end
          end
        end
        st_sack: if (step) begin
          qtr_r <= qtr_r + 2'h1;
          if (qtr_r == 2'h0) begin sda_low_r <= 1'b0; end                 // [RULE_06]
          if (qtr_r == 2'h1) begin scl_low_r <= 1'b0; end
          if (qtr_r == 2'h2 && sda_s_r) begin nack_r <= 1'b1; end         // [RULE_23]
          if (qtr_r == 2'h3) begin
            scl_low_r <= 1'b1;
            bit_r     <= 3'h7;
            if (nack_r) begin
              state_r <= st_stop;
            end else begin
              unique case (phase_r)
                ph_slave_w: begin
                  phase_r <= ph_word;
                  shift_r <= word_r;                                       // [RULE_11]
                  state_r <= st_send;
                end
                ph_word: begin
                  // write sends data; read restarts
                  phase_r <= read_r ? ph_slave_r : ph_data;                // [RULE_07]
                  shift_r <= wdata_r;
                  state_r <= read_r ? st_start : st_send;                  // [RULE_14]
                  sda_low_r <= 1'b0;
                end
                ph_data:    state_r <= st_stop;                            // [RULE_13]
                ph_slave_r: begin
                  phase_r <= ph_read;
                  state_r <= st_recv;
                end
                default:    state_r <= st_stop;
              endcase
            end
          end
        end
        st_recv: if (step) begin
          qtr_r <= qtr_r + 2'h1;
          if (qtr_r == 2'h0) begin sda_low_r <= 1'b0; end
          if (qtr_r == 2'h1) begin scl_low_r <= 1'b0; end
          if (qtr_r == 2'h2) begin shift_r <= {shift_r[6:0], sda_s_r}; end // [RULE_01]
          if (qtr_r == 2'h3) begin
            scl_low_r <= 1'b1;
            bit_r     <= bit_r - 3'h1;
            if (bit_r == 3'h0) begin
              rdata_r <= shift_r;
              count_r <= count_r - 8'h01;
              state_r <= st_mack;
            end
          end
        end
        st_mack: if (step) begin
          qtr_r <= qtr_r + 2'h1;
          // ack only while more bytes are wanted
          if (qtr_r == 2'h0) begin sda_low_r <= (count_r != 8'h00); end  // [RULE_08] [RULE_15]
          if (qtr_r == 2'h1) begin scl_low_r <= 1'b0; end
          if (qtr_r == 2'h3) begin
            scl_low_r <= 1'b1;
            bit_r     <= 3'h7;
            state_r   <= (count_r != 8'h00) ? st_recv : st_stop;
          end
        end
        st_stop: if (step) begin
          // data rises while clock high
          qtr_r <= qtr_r + 2'h1;
          if (qtr_r == 2'h0) begin sda_low_r <= 1'b1; end
          if (qtr_r == 2'h1) begin scl_low_r <= 1'b0; end
          if (qtr_r == 2'h2) begin sda_low_r <= 1'b0; end                 // [RULE_05]
          if (qtr_r == 2'h3) begin state_r <= st_done; end
        end
        st_done: begin
          busy_r  <= 1'b0;
          done_r  <= 1'b1;
          state_r <= st_idle;
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // clock is only ever released while data is stable or framing
  sda_change_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == st_send && !scl_low_r) |-> $stable(sda_low_r))
    else $error("data changed while clock released"); // [RULE_02]

  // data released when idle
  idle_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == st_idle) |-> (!sda_oe && !scl_oe))
    else $error("pins driven while idle"); // [RULE_03]

  // acknowledge phase releases data
  ack_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == st_sack && !scl_low_r) |-> !sda_low_r)
    else $error("data held during device acknowledge"); // [RULE_06]

  // refused byte leads to stop
  nack_stop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == st_sack && step && qtr_r == 2'h3 && nack_r) |=> (state_r == st_stop))
    else $error("no stop after refusal"); // [RULE_23]

  // last read byte not acknowledged
  last_nack_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == st_mack && !scl_low_r && count_r == 8'h00) |-> !sda_low_r)
    else $error("last read byte acknowledged"); // [RULE_15]

  // done follows stop
  stop_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == st_done) |=> (!busy_r && done_r && state_r == st_idle))
    else $error("transfer did not finish"); // [RULE_05]

  // start pulls data low while clock released
  start_shape_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == st_start && step && qtr_r == 2'h1) |=> (sda_low_r && !scl_low_r))
    else $error("bad start condition"); // [RULE_04]

  // read id carries direction one
  read_dir_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_r == st_start && step && qtr_r == 2'h3 && phase_r == ph_slave_r) |=> shift_r[0])
    else $error("read id without direction bit"); // [RULE_10]

endmodule : rtc_i2c_host

//--- hdl/rtc_host_regs.svh
// register offsets, field positions and timing counts for the rtc bus master
`ifndef RTC_HOST_REGS_SVH
`define RTC_HOST_REGS_SVH
// own command/status registers of the master
`define HOST_CTRL_OFS      8'h00
`define HOST_ADDR_OFS      8'h04
`define HOST_WDATA_OFS     8'h08
`define HOST_RDATA_OFS     8'h0c
`define HOST_STATUS_OFS    8'h10
`define HOST_COUNT_OFS     8'h14
`define HOST_DIV_OFS       8'h18
// ctrl fields
`define CTRL_GO_BIT        0
`define CTRL_READ_BIT      1
`define CTRL_SPACE_BIT     2
`define CTRL_CUR_BIT       3
// status fields
`define STAT_BUSY_BIT      0
`define STAT_DONE_BIT      1
`define STAT_NACK_BIT      2
// device map
`define DEV_ID_REGS        7'h6f
`define DEV_ID_USER        7'h57
`define DEV_TURNOVER_OFS   8'h2c
`define DEV_HOTCURVE_OFS   8'h2d
`define DEV_REG_WRAP       8'h2f
`define DEV_USER_TOP       8'h7f
`define TURNOVER_CODE_W    5
`define HOT_CURVE_W        7
// timing: quarter of the serial clock period, 2500 ns at 100 mhz sys_clk
`define QUARTER_NS         2500
`define SYS_PERIOD_NS      10
`define QUARTER_CYC        (`QUARTER_NS / `SYS_PERIOD_NS)
`endif

//--- hdl/rtc_host_pkg.sv
// types for the rtc bus master
package rtc_host_pkg;
  typedef enum logic [3:0] {
    st_idle, st_start, st_send, st_sack, st_recv, st_mack, st_stop, st_done
  } host_state_t;
  typedef enum logic [2:0] {
    ph_slave_w, ph_word, ph_data, ph_restart, ph_slave_r, ph_read
  } host_phase_t;
endpackage : rtc_host_pkg

//--- verification/rtc_dev_model.sv
// behavioural two-wire rtc slave: register space, user memory, presets
module rtc_dev_model #(
  parameter logic [4:0] TURN_CODE = 5'h13,  // preset turnover code, 23.5 deg
  parameter logic [6:0] HOT_BITS  = 7'h46   // preset hot curvature magnitude
) (
  // bus lines, pulled up
  input  wire logic scl,
  input  wire logic sda,
  // fault and pacing controls
  input  wire logic mute,
  input  wire logic slow,
  // pull-downs
  output logic      sda_oe,
  output logic      scl_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [0:47];  // register space
  logic [7:0] user [0:127]; // user memory
  logic [7:0] sh;           // receive shifter
  logic [7:0] ptr;          // word pointer
  logic [7:0] ob;           // byte being sent
  logic       up;           // power-up done
  logic       on;           // addressed
  logic       tx;           // sending
  logic       usr;          // user memory picked
  logic       rd;           // read requested
  logic       ok;           // ack decision
  logic       mnack;        // master refused byte
  int         k;            // bit slot
  int         nb;           // byte count
  // pointer step with register-space wrap
  function automatic logic [7:0] step(input logic [7:0] p, input logic u);
    return u ? {1'b0, p[6:0] + 7'h01} : (p == 8'h2f ? 8'h00 : p + 8'h01);
  endfunction : step
  // power-up: lines released, pointer cleared, presets loaded
  initial begin
    sda_oe = 1'b0;
    scl_oe = 1'b0;
    on = 1'b0;
    up = 1'b0;
    ptr = 8'h00;
    for (int i = 0; i < 48; i++) regs[i] = 8'h5a ^ 8'(i);
    for (int i = 0; i < 128; i++) user[i] = 8'h00;
    regs[8'h2c] = {3'h0, TURN_CODE};
    regs[8'h2d] = {1'h0, HOT_BITS};
    #200 up = 1'b1;
  end
  // start: data falls while clock high
  always @(negedge sda) if (scl === 1'b1 && up) begin
    on = 1'b1;
    tx = 1'b0;
    k = -1;
    nb = 0;
    sda_oe = 1'b0;
  end
  // stop: back to standby
  always @(posedge sda) if (scl === 1'b1) begin
    on = 1'b0;
    sda_oe = 1'b0;
  end
  // sample on rising clock
  always @(posedge scl) if (on) begin
    if (k < 8 && !tx) sh = {sh[6:0], sda};
    if (k == 8 && tx) mnack = sda;
  end
  // advance on falling clock
  always @(negedge scl) if (on) begin
    k = (k == 8) ? 0 : k + 1;
    ok = 1'b1;
    if (k == 8 && !tx) begin  // byte received
      if (nb == 0) begin
        usr = (sh[7:1] == 7'h57);
        ok = (sh[7:1] == 7'h6f || usr) && !mute;
        rd = sh[0];
      end else if (nb == 1) ptr = sh;
      else begin  // data write, presets kept
        if (usr) user[ptr[6:0]] = sh;
        else if (ptr != 8'h2c && ptr != 8'h2d) regs[ptr] = sh;
        ptr = step(ptr, usr);
      end
      nb++;
      mnack = 1'b0;
      sda_oe = ok;
      on = ok;
    end else if (k == 8) sda_oe = 1'b0;
    else if (k == 0) begin  // ack slot over
      if (rd && nb == 1) tx = 1'b1;
      if (tx && mnack) on = 1'b0;
      else if (tx) begin
        ob = usr ? user[ptr[6:0]] : regs[ptr];
        ptr = step(ptr, usr);
      end
      // release only when no data bit follows, one drive per step
      if (!(tx && on)) sda_oe = 1'b0;
    end
    if (tx && on && k < 8) sda_oe = ~ob[7 - k];
  end
  // optional clock stretch
  always @(negedge scl) if (slow && on) begin
    scl_oe = 1'b1;
    #3000 scl_oe = 1'b0;
  end
endmodule : rtc_dev_model

//--- verification/test_rtc_i2c_host.sv
// self-checking bench for the rtc two-wire host
`include "rtc_host_regs.svh"
module test_rtc_i2c_host;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] USP = 32'h1 << `CTRL_SPACE_BIT;  // user space
  localparam logic [31:0] CUR = 32'h1 << `CTRL_CUR_BIT;    // current address
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        scl_oe;
  logic        sda_oe;
  logic        scl_o;    // host clock drive level
  logic        sda_o;    // host data drive level
  logic        dscl_oe;  // model clock stretch
  logic        dsda_oe;  // model data pull
  logic        mute = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] v;
  int          miscompares = 0;
  int          checked = 0;
  // pulled-up wires
  wire scl = ~(scl_oe | dscl_oe);
  wire sda = ~(sda_oe | dsda_oe);
  always #5 sys_clk = ~sys_clk;
  rtc_i2c_host #(.QUARTER(5)) rtc_i2c_host_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl),
    .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe));
  rtc_dev_model rtc_dev_model_inst (
    .scl(scl), .sda(sda), .mute(mute), .slow(slow), .sda_oe(dsda_oe), .scl_oe(dscl_oe));
  // expected register-space contents
  function automatic logic [7:0] pre(input int i);
    return 8'h5a ^ 8'(i);
  endfunction : pre
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // register read, data in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask : rd
  // start a transfer, poll for done, check and clear status
  task automatic run(input logic [31:0] c, input logic [31:0] st);
    logic [31:0] s;
    int n;
    wr(`HOST_CTRL_OFS, c);
    n = 0;
    do begin
      rd(`HOST_STATUS_OFS, s);
      n++;
    end while (s[`STAT_DONE_BIT] !== 1'b1 && n < 20000);
    chk("status", s, st);
    wr(`HOST_STATUS_OFS, 32'h6);
  endtask : run
  // read n bytes from a, compare the last
  task automatic get(input logic [31:0] c, input logic [7:0] a, input int n,
                     input logic [7:0] e);
    wr(`HOST_ADDR_OFS, {24'h0, a});
    wr(`HOST_COUNT_OFS, 32'(n));
    run(c | 32'h3, 32'h2);
    rd(`HOST_RDATA_OFS, v);
    chk("read byte", v, {24'h0, e});
    rd(`HOST_COUNT_OFS, v);
    chk("bytes left", v, 32'h0);
  endtask : get
  // single-byte write
  task automatic put(input logic [31:0] c, input logic [7:0] a, input logic [7:0] d);
    wr(`HOST_ADDR_OFS, {24'h0, a});
    wr(`HOST_WDATA_OFS, {24'h0, d});
    run(c | 32'h1, 32'h2);
  endtask : put
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // hang guard
  initial begin
    #800000;
    miscompares++;
    close_out;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`HOST_STATUS_OFS, v);
    chk("idle status", v, 32'h0);
    chk("idle lines", {30'h0, scl, sda}, 32'h3);
    chk("pin drive levels", {30'h0, scl_o, sda_o}, 32'h0);
    wr(`HOST_DIV_OFS, 32'h6);
    rd(`HOST_DIV_OFS, v);
    chk("divider", v, 32'h6);
    get(CUR, 8'h00, 1, pre(0));
    put(32'h0, 8'h05, 8'ha5);
    get(32'h0, 8'h05, 1, 8'ha5);
    put(32'h0, 8'h2c, 8'hff);
    get(32'h0, 8'h2c, 1, 8'h13);
    put(32'h0, 8'h2d, 8'hff);
    get(32'h0, 8'h2d, 1, 8'h46);
    get(32'h0, 8'h2e, 3, pre(0));
    get(CUR, 8'h00, 1, pre(1));
    put(USP, 8'h7f, 8'h3c);
    rd(`HOST_CTRL_OFS, v);
    chk("ctrl readback", v, 32'h4);
    get(USP, 8'h7f, 1, 8'h3c);
    get(32'h0, 8'h2f, 1, pre(47));
    slow <= 1'b1;
    get(32'h0, 8'h05, 2, pre(6));
    slow <= 1'b0;
    mute <= 1'b1;
    run(32'h1, 32'h6);
    mute <= 1'b0;
    rd(`HOST_STATUS_OFS, v);
    chk("status cleared", v, 32'h0);
    chk("lines after stop", {30'h0, scl, sda}, 32'h3);
    rd(8'h1c, v);
    chk("unmapped", v, 32'h0);
    close_out;
  end
endmodule : test_rtc_i2c_host
